/* src/nvc_eeprom_ctrl.sv */
/*
  EEPROM access controller: address, data and control registers on
  the CPU I/O port, a 64-byte array, self-timed programming, stall
  and ready interrupt. Assumes the core holds io_addr_i stable with
  one-cycle io_we_i/io_re_i strobes and honours stall_o.
  Limitation: the RC timebase is a divider of the CPU clock, so the
  write time scales with the clock rather than drifting like an
  analog oscillator; the registered tick adds one clock at the end.
*/
`timescale 1ns/1ps
`default_nettype none
module nvc_eeprom_ctrl #(
  parameter int PROG_CYC = nvc_pkg::PROG_RC_CYC, // RC cycles per write
  parameter int RC_DIV   = 8                     // Clocks per RC cycle
) (
  input  wire logic       clk_i,         // CPU clock
  input  wire logic       rst_i,         // Sync reset
  input  wire logic [5:0] io_addr_i,     // I/O address
  input  wire logic [7:0] io_wdata_i,    // Write data
  input  wire logic       io_we_i,       // Write strobe
  input  wire logic       io_re_i,       // Read strobe
  input  wire logic       gie_i,         // Global irq enable
  output logic      [7:0] io_rdata_o,    // Read data
  output logic            stall_o,       // Halt CPU
  output logic            ready_irq_o    // Ready interrupt
);
  localparam int AW = nvc_pkg::ADDR_W;   // Address width

  logic [7:0]    mem [0:(1<<AW)-1];      // Storage array
  logic [AW-1:0] nv_address_reg;         // No reset on purpose
  logic [7:0]    nv_data_reg;            // Data register
  logic          ready_irq_enable;       // Control bit 3
  logic          master_write_arm;       // Control bit 2
  logic          write_strobe;           // Control bit 1
  logic          read_strobe;            // Control bit 0
  logic [2:0]    arm_cnt;                // Arm lifetime count
  logic [2:0]    stall_cnt;              // Stall cycles left
  logic [12:0]   prog_cnt;               // RC cycles elapsed
  logic          rc_tick;                // RC oscillator pulse
  logic          wr_ctrl;                // Control register write
  logic          wr_addr;                // Address register write
  logic          wr_data;                // Data register write
  logic          rd_addr;                // Address register read
  logic          rd_data;                // Data register read
  logic          rd_ctrl;                // Control register read
  logic          start_wr;               // Programming starts
  logic          start_rd;               // Array read starts
  logic          abort_wr;               // Programming killed
  logic          prog_done;              // Programming finished
  logic [7:0]    ctrl_view;              // Control readback

  // Decode of I/O accesses
  assign wr_ctrl  = io_we_i && io_addr_i == nvc_pkg::CTRL_OFS;
  assign wr_addr  = io_we_i && io_addr_i == nvc_pkg::ADDR_OFS;
  assign wr_data  = io_we_i && io_addr_i == nvc_pkg::DATA_OFS;
  assign rd_ctrl  = io_re_i && io_addr_i == nvc_pkg::CTRL_OFS;
  assign rd_addr  = io_re_i && io_addr_i == nvc_pkg::ADDR_OFS;
  assign rd_data  = io_re_i && io_addr_i == nvc_pkg::DATA_OFS;
  // Write starts only while armed and idle
  assign start_wr = wr_ctrl && io_wdata_i[nvc_pkg::BIT_WS] && master_write_arm
                    && !write_strobe;
  // Read start does not wait for a running write; software must poll
  // the write strobe first, as the read overwrites the byte being programmed
  assign start_rd = wr_ctrl && io_wdata_i[nvc_pkg::BIT_RS];
  // Writing address or data mid-program kills the write
  assign abort_wr = write_strobe && (wr_addr || wr_data);
  assign prog_done = write_strobe && rc_tick &&
                     prog_cnt == 13'(PROG_CYC - 1);
  assign ctrl_view = {4'h0, ready_irq_enable, master_write_arm,
                      write_strobe, read_strobe};

  // RC stand-in runs only while programming, so every write starts
  // from a fresh divider phase and idle costs no toggling
  nvc_rc_tick #(.DIV(RC_DIV)) u_rc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (write_strobe),
    .tick_o (rc_tick)
  );

  // Address register survives reset
  // Only six bits are stored; the top two read back as zero
  always_ff @(posedge clk_i)
  begin
    if (wr_addr)
      nv_address_reg <= io_wdata_i[AW-1:0];
  end

  // Data register: CPU write or read result
  // Read result wins over a data write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      nv_data_reg <= 8'h00;
    else if (start_rd)
      nv_data_reg <= mem[nv_address_reg];
    else if (wr_data)
      nv_data_reg <= io_wdata_i;
  end

  // Array update at end of programming
  // An abort before the final RC tick never gets here, so the old byte survives; one in the tick cycle still programs
  always_ff @(posedge clk_i)
  begin
    if (prog_done)
      mem[nv_address_reg] <= nv_data_reg;
  end

  // Irq enable and arm with its timeout
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ready_irq_enable <= 1'b0;
      master_write_arm <= 1'b0;
      arm_cnt          <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        ready_irq_enable <= io_wdata_i[nvc_pkg::BIT_RIE];
      // Arm only accepted with write strobe written zero; arm and
      // strobe in one write is ignored, so a stray byte cannot program
      if (wr_ctrl && io_wdata_i[nvc_pkg::BIT_MWA] && !io_wdata_i[nvc_pkg::BIT_WS])
      begin
        master_write_arm <= 1'b1;
        arm_cnt          <= nvc_pkg::ARM_CYCLES - 3'h1;
      end
      // The strobe consumes the arm, otherwise the arm times out
      else if (start_wr || arm_cnt == 3'h0)
        master_write_arm <= 1'b0;
      else
        arm_cnt <= arm_cnt - 3'h1;
    end
  end

  // Write strobe busy flag and programming timer
  // Set and clear never meet: start needs the flag low, done and
  // abort need it high, so no priority question arises
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      write_strobe <= 1'b0;
      prog_cnt     <= 13'h0000;
    end
    else if (start_wr)
    begin
      write_strobe <= 1'b1;
      prog_cnt     <= 13'h0000;
    end
    else if (prog_done || abort_wr)
      write_strobe <= 1'b0;
    else if (write_strobe && rc_tick)
      prog_cnt <= prog_cnt + 13'h0001;
  end

  // Read strobe clears with the stall, never visible after
  // Set wins should a new read land on the last stall cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      read_strobe <= 1'b0;
    else if (start_rd)
      read_strobe <= 1'b1;
    else if (stall_cnt == 3'h1)
      read_strobe <= 1'b0;
  end

  // CPU halt counter
  // A control write setting both strobes gets the longer read stall
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stall_cnt <= 3'h0;
      stall_o   <= 1'b0;
    end
    else if (start_rd)
    begin
      stall_cnt <= nvc_pkg::RD_STALL;
      stall_o   <= 1'b1;
    end
    else if (start_wr)
    begin
      stall_cnt <= nvc_pkg::WR_STALL;
      stall_o   <= 1'b1;
    end
    else if (stall_cnt != 3'h0)
    begin
      stall_cnt <= stall_cnt - 3'h1;
      stall_o   <= stall_cnt != 3'h1;
    end
  end

  // Level interrupt while idle and enabled
  // Registered, so the level follows enable changes one clock late
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ready_irq_o <= 1'b0;
    else
      ready_irq_o <= ready_irq_enable && gie_i && !write_strobe;
  end

  // Registered read mux, unmapped reads zero
  // Zero on idle cycles lets the core merge several read buses
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      io_rdata_o <= 8'h00;
    else if (rd_addr)
      io_rdata_o <= {2'b00, nv_address_reg};
    else if (rd_data)
      io_rdata_o <= nv_data_reg;
    else if (rd_ctrl)
      io_rdata_o <= ctrl_view;
    else
      io_rdata_o <= 8'h00;
  end
endmodule : nvc_eeprom_ctrl
`default_nettype wire

/* src/nvc_pkg.sv */
/*
  Constants for the CPU-side data EEPROM access controller: I/O
  offsets, control bit positions, stall and timing counts.
  Assumes the CPU core decodes its I/O space and drives the port.
*/
package nvc_pkg;
  localparam logic [5:0] ADDR_OFS     = 6'h1E; // Address register
  localparam logic [5:0] DATA_OFS     = 6'h1D; // Data register
  localparam logic [5:0] CTRL_OFS     = 6'h1C; // Control register
  localparam int         BIT_RIE      = 3;     // Ready irq enable
  localparam int         BIT_MWA      = 2;     // Master write arm
  localparam int         BIT_WS       = 1;     // Write strobe
  localparam int         BIT_RS       = 0;     // Read strobe
  localparam logic [2:0] ARM_CYCLES   = 3'h4;  // Arm lifetime
  localparam logic [2:0] WR_STALL     = 3'h2;  // Stall on write
  localparam logic [2:0] RD_STALL     = 3'h4;  // Stall on read
  localparam int         PROG_RC_CYC  = 4096;  // Programming length
  localparam int         ADDR_W       = 6;     // Address width
endpackage : nvc_pkg

/* src/nvc_rc_tick.sv */
/*
  Divider standing in for the calibrated RC oscillator: one-cycle
  enable pulse every DIV clocks. Assumes one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nvc_rc_tick #(
  parameter int DIV = 8                  // Clocks per RC cycle
) (
  input  wire logic clk_i,               // System clock
  input  wire logic rst_i,               // Sync reset
  input  wire logic run_i,               // Count while high
  output logic      tick_o               // RC cycle pulse
);
  logic [15:0] cnt;                      // Divider count

  // Free divide while running, restart otherwise
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt    <= 16'h0000;
      tick_o <= 1'b0;
    end
    else if (cnt == 16'(DIV - 1))
    begin
      cnt    <= 16'h0000;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt    <= cnt + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule : nvc_rc_tick
`default_nettype wire

/* tb/nvc_ctrl_props.sv */
/* Port checker for the EEPROM access controller.
   Assumes one clock domain and the package offsets. */
`timescale 1ns/1ps
`default_nettype none
module nvc_ctrl_props (
  input wire logic       clk_i,       // CPU clock
  input wire logic       rst_i,       // Sync reset
  input wire logic [5:0] io_addr_i,   // I/O address
  input wire logic [7:0] io_wdata_i,  // Write data
  input wire logic       io_we_i,     // Write strobe
  input wire logic       io_re_i,     // Read strobe
  input wire logic       gie_i,       // Global irq enable
  input wire logic [7:0] io_rdata_o,  // Read data
  input wire logic       stall_o,     // Halt CPU
  input wire logic       ready_irq_o  // Ready interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic ctl_we = io_we_i && io_addr_i == nvc_pkg::CTRL_OFS; // Control write
  // Arm with strobe bit low, then the strobe itself
  sequence arm_wr; ctl_we && io_wdata_i[2:1] == 2'b10; endsequence
  sequence go_wr; ctl_we && io_wdata_i[1]; endsequence
  wr_stall_a: assert property (arm_wr ##3 go_wr |=> stall_o[*2] ##1 !stall_o)
    else $error("write stall length wrong");
  rd_stall_a: assert property (ctl_we && io_wdata_i[0]
    |=> stall_o[*4] ##1 !stall_o)
    else $error("read stall length wrong");
  stall_cause_a: assert property ($rose(stall_o) |-> $past(ctl_we))
    else $error("stall without control write");
  late_arm_a: assert property (arm_wr ##6 go_wr |=> !stall_o)
    else $error("expired arm still started a write");
  addr_hi_a: assert property (io_re_i && io_addr_i == nvc_pkg::ADDR_OFS
    |=> io_rdata_o[7:6] == 2'h0)
    else $error("address upper bits not zero");
  ctl_rsv_a: assert property (io_re_i && io_addr_i == nvc_pkg::CTRL_OFS
    |=> io_rdata_o[7:4] == 4'h0)
    else $error("control reserved bits not zero");
  irq_gate_a: assert property (!gie_i |=> !ready_irq_o)
    else $error("ready irq without global enable");
  // Irq must drop while programming runs
  prog_quiet_a: assert property (arm_wr ##3 go_wr |=> ##1 !ready_irq_o[*3])
    else $error("ready irq during programming");
endmodule : nvc_ctrl_props
bind nvc_eeprom_ctrl nvc_ctrl_props i_props (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
  .io_wdata_i(io_wdata_i), .io_we_i(io_we_i), .io_re_i(io_re_i), .gie_i(gie_i),
  .io_rdata_o(io_rdata_o), .stall_o(stall_o), .ready_irq_o(ready_irq_o));
`default_nettype wire

/* tb/nvc_cpu_model.sv */
/* CPU core model: I/O accesses at the falling edge, halts on stall.
   Assumes the bench pops exp_q as read data appears. */
`timescale 1ns/1ps
`default_nettype none
module nvc_cpu_model (
  input  wire logic       clk_i,    // CPU clock
  input  wire logic       stall_i,  // Core halted
  output logic      [5:0] addr_o,   // I/O address
  output logic      [7:0] wdata_o,  // Write data
  output logic            we_o,     // Write strobe
  output logic            re_o      // Read strobe
);
  logic [7:0] exp_q[$];             // Expected read data
  initial {addr_o, wdata_o, we_o, re_o} = 16'h0000;
  // One access; released bus shows inverted values, then wait out the halt
  task automatic acc(input logic [5:0] a, input logic [7:0] d, input logic rd);
    @(negedge clk_i);
    {addr_o, wdata_o, we_o, re_o} = {a, d, !rd, rd};
    @(negedge clk_i);
    {addr_o, wdata_o, we_o, re_o} = {~a, ~d, 2'b00};
    @(negedge clk_i);
    while (stall_i) @(negedge clk_i);
  endtask : acc
  // Register read with its expected value noted first
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(a, 8'h00, 1'b1);
  endtask : rd
  // Program sequence; gap delays the strobe past the arm window
  task automatic prog(input logic [5:0] a, input logic [7:0] d, input int gap);
    acc(nvc_pkg::ADDR_OFS, {2'b00, a}, 1'b0);
    acc(nvc_pkg::DATA_OFS, d, 1'b0);
    acc(nvc_pkg::CTRL_OFS, 8'h0C, 1'b0);  // Arm with strobe low
    repeat (gap) @(negedge clk_i);
    acc(nvc_pkg::CTRL_OFS, 8'h0A, 1'b0);  // Strobe three cycles plus gap after the arm
  endtask : prog
  // Load address, junk in its read-only bits, then start a read
  task automatic rd_byte(input logic [5:0] a);
    acc(nvc_pkg::ADDR_OFS, {2'b11, a}, 1'b0);
    acc(nvc_pkg::CTRL_OFS, 8'h09, 1'b0);
  endtask : rd_byte
endmodule : nvc_cpu_model
`default_nettype wire

/* tb/testbench.sv */
/* Self-checking bench for the EEPROM access controller.
   Assumes shortened programming: 8 RC cycles of one clock each. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;  // CPU clock
  logic        rst = 1'b1;  // Sync reset
  logic        gie = 1'b0;  // Global irq enable
  logic        re_q = 1'b0; // Read seen last edge
  logic [5:0]  addr, a;     // Bus address, target
  logic [7:0]  wdata, rdata, d;
  logic        we, re, stall, irq;
  logic [31:0] lfsr = 32'h1E4E;
  logic [7:0]  mem [64];    // Expected array
  int          error_cnt = 0;
  int          tests_run = 0;
  initial forever #5 clk = ~clk;
  nvc_eeprom_ctrl #(.PROG_CYC(8), .RC_DIV(1)) i_dut (.clk_i(clk), .rst_i(rst),
    .io_addr_i(addr), .io_wdata_i(wdata), .io_we_i(we), .io_re_i(re), .gie_i(gie),
    .io_rdata_o(rdata), .stall_o(stall), .ready_irq_o(irq));
  nvc_cpu_model i_cpu (.clk_i(clk), .stall_i(stall), .addr_o(addr), .wdata_o(wdata),
    .we_o(we), .re_o(re));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  // Read data is valid the cycle after the strobe
  always @(posedge clk) re_q <= re;
  always @(negedge clk)
    if (re_q === 1'b1 && i_cpu.exp_q.size() > 0)
      check(rdata, i_cpu.exp_q.pop_front());
  // Hang guard, far beyond the expected run
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    gie = 1'b1;
    i_cpu.acc(nvc_pkg::CTRL_OFS, 8'h08, 1'b0);
    @(negedge clk);
    check({7'h00, irq}, 8'h01);
    gie = 1'b0;
    repeat (2) @(negedge clk);
    check({7'h00, irq}, 8'h00);
    gie = 1'b1;
    // Random bytes to random places, then read back
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      a = lfsr[5:0];
      d = lfsr[15:8];
      i_cpu.prog(a, d, 0);
      i_cpu.rd(nvc_pkg::CTRL_OFS, 8'h0A);
      check({7'h00, irq}, 8'h00);
      repeat (12) @(negedge clk);
      mem[a] = d;
      i_cpu.rd(nvc_pkg::CTRL_OFS, 8'h08);
      i_cpu.rd_byte(a);
      i_cpu.rd(nvc_pkg::DATA_OFS, mem[a]);
      i_cpu.rd(nvc_pkg::ADDR_OFS, {2'b00, a});
    end
    // Strobe after the arm expired does nothing
    i_cpu.prog(a, ~d, 3);
    i_cpu.rd(nvc_pkg::CTRL_OFS, 8'h08);
    // Arm written together with the strobe bit is refused
    i_cpu.acc(nvc_pkg::CTRL_OFS, 8'h0E, 1'b0);
    i_cpu.rd(nvc_pkg::CTRL_OFS, 8'h08);
    // Data write mid-programming aborts, array kept
    i_cpu.prog(a, ~d, 0);
    i_cpu.acc(nvc_pkg::DATA_OFS, d, 1'b0);
    i_cpu.rd(nvc_pkg::CTRL_OFS, 8'h08);
    repeat (12) @(negedge clk);
    i_cpu.rd_byte(a);
    i_cpu.rd(nvc_pkg::DATA_OFS, mem[a]);
    // Mid-run reset keeps the address
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    i_cpu.rd(nvc_pkg::ADDR_OFS, {2'b00, a});
    i_cpu.rd(nvc_pkg::CTRL_OFS, 8'h00);
    final_report();
  end
endmodule : testbench
`default_nettype wire
